// ### src/multimode_capture_timer.sv
// multimode capture timer: counter, reload/capture register, control
// assumes port direction/data bits and master enable come from core logic
`include "mct_consts.svh"

module multimode_capture_timer (
  input  wire logic       CORE_CLK,
  input  wire logic       RST_B,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       PIN_I,
  output logic            PIN_O,
  output logic            PIN_OE,
  input  wire logic       PORT_DIR,
  input  wire logic       PORT_DATA,
  input  wire logic       MASTER_IE,
  output logic            IRQ
);

  // ----------------------------------------
  // instruction clock enable
  // ----------------------------------------
  logic [`DIV_W-1:0] div_ff;
  logic              tick_ff;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == `DIV_W'(`INSTR_DIV - 1));
      if (div_ff == `DIV_W'(`INSTR_DIV - 1)) begin
        div_ff <= '0;
      end else begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------
  logic sync1_ff;
  logic sync2_ff;
  logic samp_ff;
  logic rise;
  logic fall;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= PIN_I;
      sync2_ff <= sync1_ff;
    end
  end

  // sampled once per instruction cycle, so two ticks per counted edge
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      samp_ff <= 1'b0;
    end else if (tick_ff) begin
      samp_ff <= sync2_ff;
    end
  end

  assign rise = tick_ff & sync2_ff & ~samp_ff;
  assign fall = tick_ff & ~sync2_ff & samp_ff;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [2:0] mode_ff;
  logic       run_ff;
  logic       pend_ff;
  logic       ien_ff;
  logic       ctyp_ff;
  logic       wr_ctrl;
  logic       wr_clo;
  logic       wr_chi;
  logic       wr_rlo;
  logic       wr_rhi;
  logic       capmode;

  mct_pkg::mode_e mode;

  function automatic mct_pkg::mode_e decode(input logic [2:0] m);
    case (m[2:1])
      2'h0:    decode = mct_pkg::M_EVENT;
      2'h2:    decode = mct_pkg::M_PWM;
      2'h1:    decode = mct_pkg::M_CAPT;
      default: decode = mct_pkg::M_DIFF;
    endcase
  endfunction

  assign mode    = decode(mode_ff);
  assign capmode = (mode == mct_pkg::M_CAPT) || (mode == mct_pkg::M_DIFF);
  assign wr_ctrl = WR && (ADDR == `ADDR_CTRL);
  assign wr_clo  = WR && (ADDR == `ADDR_CNT_LO);
  assign wr_chi  = WR && (ADDR == `ADDR_CNT_HI);
  assign wr_rlo  = WR && (ADDR == `ADDR_RLD_LO);
  assign wr_rhi  = WR && (ADDR == `ADDR_RLD_HI);

  // ----------------------------------------
  // counting engine
  // ----------------------------------------
  logic [15:0]    cnt_ff;
  logic [15:0]    rld_ff;
  logic [15:0]    nxt_cnt;
  logic           reload_ev;
  logic           wrap_ev;
  logic           cap_ev;
  logic           edge_a;
  logic           edge_b;
  mct_pkg::diff_e dstate_ff;
  mct_pkg::diff_e nxt_dstate;

  // first edge follows bit 5, second edge polarity is bit 5 xor bit 1
  assign edge_a = mode_ff[0] ? fall : rise;
  assign edge_b = (mode_ff[0] ^ ctyp_ff) ? rise : fall;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_dstate = dstate_ff;
    reload_ev  = 1'b0;
    wrap_ev    = 1'b0;
    cap_ev     = 1'b0;
    case (mode)
      mct_pkg::M_PWM: begin
        if (run_ff && tick_ff) begin
          if (cnt_ff == 16'h0000) begin
            nxt_cnt   = rld_ff;
            reload_ev = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
      end
      mct_pkg::M_EVENT: begin
        if (run_ff && edge_a) begin
          if (cnt_ff == 16'h0000) begin
            nxt_cnt   = rld_ff;
            reload_ev = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
      end
      mct_pkg::M_CAPT: begin
        if (tick_ff) begin
          nxt_cnt = cnt_ff - 1'b1;
          wrap_ev = (cnt_ff == 16'h0000);
        end
        cap_ev = edge_a;
      end
      mct_pkg::M_DIFF: begin
        case (dstate_ff)
          mct_pkg::D_ARM: begin
            if (edge_a) begin
              nxt_cnt    = 16'h0000;
              nxt_dstate = mct_pkg::D_RUN;
            end
          end
          mct_pkg::D_RUN: begin
            if (edge_b) begin
              cap_ev     = 1'b1;
              nxt_dstate = mct_pkg::D_DONE;
            end else if (tick_ff) begin
              nxt_cnt = cnt_ff + 16'h0001;
              wrap_ev = (cnt_ff == 16'hFFFF);
            end
          end
          default: begin
            nxt_dstate = mct_pkg::D_DONE;
          end
        endcase
      end
      default: begin
        nxt_cnt = cnt_ff;
      end
    endcase
  end

  // software load of the counter wins over counting in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_ff <= `CNT_RST;
    end else if (wr_clo) begin
      cnt_ff <= {cnt_ff[15:8], WDATA};
    end else if (wr_chi) begin
      cnt_ff <= {WDATA, cnt_ff[7:0]};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // a capture must not be lost, so it beats a software write
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rld_ff <= `RLD_RST;
    end else if (cap_ev) begin
      rld_ff <= cnt_ff;
    end else if (wr_rlo) begin
      rld_ff <= {rld_ff[15:8], WDATA};
    end else if (wr_rhi) begin
      rld_ff <= {WDATA, rld_ff[7:0]};
    end
  end

  // any control write re-arms the difference sequencer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dstate_ff <= mct_pkg::D_ARM;
    end else if (wr_ctrl) begin
      dstate_ff <= mct_pkg::D_ARM;
    end else begin
      dstate_ff <= nxt_dstate;
    end
  end

  // ----------------------------------------
  // control bits, set wins over clear
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ff <= 3'(`CTRL_RST >> `MODE_LO);
      ien_ff  <= 1'b0;
      ctyp_ff <= 1'b0;
    end else if (wr_ctrl) begin
      mode_ff <= WDATA[`MODE_HI:`MODE_LO];
      ien_ff  <= WDATA[`BIT_IEN];
      ctyp_ff <= WDATA[`BIT_CTYP];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_ff <= 1'b0;
    end else if (wrap_ev) begin
      run_ff <= 1'b1;
    end else if (wr_ctrl) begin
      run_ff <= WDATA[`BIT_RUN];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_ff <= 1'b0;
    end else if (reload_ev || cap_ev) begin
      pend_ff <= 1'b1;
    end else if (wr_ctrl) begin
      pend_ff <= WDATA[`BIT_PEND];
    end
  end

  // ----------------------------------------
  // pin, interrupt and read data
  // ----------------------------------------
  // outside toggle mode the pin follows the port data bit, which
  // also presets the level that toggling starts from
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIN_O  <= 1'b0;
      PIN_OE <= 1'b0;
    end else begin
      PIN_OE <= PORT_DIR;
      if (mode == mct_pkg::M_PWM && mode_ff[0]) begin
        if (reload_ev) begin
          PIN_O <= ~PIN_O;
        end
      end else begin
        PIN_O <= PORT_DATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= ien_ff && MASTER_IE && (pend_ff || (capmode && run_ff));
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `ADDR_CTRL:   RDATA <= {mode_ff, run_ff, pend_ff, ien_ff, ctyp_ff, 1'b0};
        `ADDR_CNT_LO: RDATA <= cnt_ff[7:0];
        `ADDR_CNT_HI: RDATA <= cnt_ff[15:8];
        `ADDR_RLD_LO: RDATA <= rld_ff[7:0];
        `ADDR_RLD_HI: RDATA <= rld_ff[15:8];
        default:      RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  logic wr_cnt;
  assign wr_cnt = wr_clo || wr_chi;

  a_pwm_reload: assert property (
    (mode == mct_pkg::M_PWM && run_ff && tick_ff && cnt_ff == 16'h0000 && !wr_cnt)
    |=> cnt_ff == $past(rld_ff))
    else $error("pwm underflow did not reload");

  a_run_stop: assert property (
    (!capmode && !run_ff && !wr_cnt) |=> $stable(cnt_ff))
    else $error("stopped counter moved");

  a_pend_set: assert property (
    reload_ev |=> pend_ff)
    else $error("reload did not set pending");

  a_pin_toggle: assert property (
    (reload_ev && mode_ff == 3'h5) |=> PIN_O != $past(PIN_O))
    else $error("pin did not toggle on underflow");

  a_irq_gate: assert property (
    IRQ |-> $past(ien_ff) && $past(MASTER_IE))
    else $error("interrupt without enables");

  a_irq_raise: assert property (
    (ien_ff && MASTER_IE && pend_ff) |=> IRQ)
    else $error("interrupt missing");

  a_capt_copy: assert property (
    (cap_ev && mode == mct_pkg::M_CAPT) |=> rld_ff == $past(cnt_ff) && pend_ff)
    else $error("capture value wrong");

  a_capt_free: assert property (
    (mode == mct_pkg::M_CAPT && tick_ff && !wr_cnt)
    |=> cnt_ff == $past(cnt_ff) - 16'h0001)
    else $error("capture counter not running");

  a_uflag_set: assert property (
    wrap_ev |=> run_ff)
    else $error("underflow flag not set");

  a_event_hold: assert property (
    (mode == mct_pkg::M_EVENT && !edge_a && !wr_cnt) |=> $stable(cnt_ff))
    else $error("event counter moved without edge");

  a_edge_once: assert property (
    rise |=> !rise [*8])
    else $error("edge counted twice");

  a_diff_hold: assert property (
    (mode == mct_pkg::M_DIFF && dstate_ff == mct_pkg::D_DONE && !wr_cnt)
    |=> $stable(cnt_ff))
    else $error("difference counter not stopped");

  a_bit0_zero: assert property (
    (RD && ADDR == `ADDR_CTRL) |=> RDATA[0] == 1'b0)
    else $error("reserved bit read nonzero");

  c_pwm_toggle: cover property (reload_ev && mode_ff == 3'h5);
  c_capture: cover property (cap_ev && mode == mct_pkg::M_CAPT);
  c_diff_done: cover property (mode == mct_pkg::M_DIFF && dstate_ff == mct_pkg::D_DONE);
  c_irq: cover property (IRQ);

endmodule

// ### src/mct_consts.svh
// register offsets, field positions, reset values and timing counts
// for the multimode capture timer; assumes an 8-bit register port

`ifndef MCT_CONSTS_SVH
`define MCT_CONSTS_SVH

`define ADDR_CTRL   3'h0
`define ADDR_CNT_LO 3'h1
`define ADDR_CNT_HI 3'h2
`define ADDR_RLD_LO 3'h3
`define ADDR_RLD_HI 3'h4

`define MODE_HI  7
`define MODE_LO  5
`define BIT_RUN  4
`define BIT_PEND 3
`define BIT_IEN  2
`define BIT_CTYP 1

`define CTRL_RST 8'h00
`define CNT_RST  16'hFFFF
`define RLD_RST  16'h0000

`define CORE_NS   20
`define INSTR_NS  1000
`define INSTR_DIV (`INSTR_NS / `CORE_NS)
`define DIV_W     6

`endif

// ### src/mct_pkg.sv
// types shared by the multimode capture timer
// assumes nothing beyond a SystemVerilog compiler
package mct_pkg;
  typedef enum logic [1:0] {M_EVENT, M_PWM, M_CAPT, M_DIFF} mode_e;
  typedef enum logic [1:0] {D_ARM, D_RUN, D_DONE} diff_e;
endpackage

// ### dv/pulse_source.sv
// partner model: external pulse source standing on the timer pin
// assumes the bench resolves the pin level from the block's output enable
module pulse_source (
  input  wire logic clk,
  output logic      lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // pin driver
  // ----------------------------------------
  initial lvl = 1'b0;

  // each level held two ticks at least, so no edge can be lost to sampling
  task automatic drive(input logic v, input int hold);
    @(posedge clk);
    lvl <= v;
    repeat ((hold < 100) ? 100 : hold) @(posedge clk);
  endtask
endmodule

// ### dv/multimode_capture_timer_test.sv
// self-checking bench for the multimode capture timer
// assumes a 50-clock instruction tick and the pulse source partner on the pin
module multimode_capture_timer_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        dir = 1'b0;
  logic        pdat = 1'b0;
  logic        mie = 1'b0;
  logic        rd_q = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        pin_o;
  logic        pin_oe;
  logic        irq;
  logic        src_lvl;
  logic        pin;
  logic        f;
  logic        s;
  logic [1:0]  kb;
  logic [15:0] e;
  logic [15:0] rld;
  logic [31:0] seed = 32'h0000_0035;
  logic [15:0] exp_q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #10 clk = ~clk;
  assign pin = pin_oe ? pin_o : src_lvl;

  multimode_capture_timer uut (
    .CORE_CLK (clk), .RST_B (rst_b), .ADDR (addr), .WDATA (wdata), .WR (wr), .RD (rd),
    .RDATA (rdata), .PIN_I (pin), .PIN_O (pin_o), .PIN_OE (pin_oe), .PORT_DIR (dir),
    .PORT_DATA (pdat), .MASTER_IE (mie), .IRQ (irq)
  );

  pulse_source src (.clk (clk), .lvl (src_lvl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] xp, input logic [7:0] m);
    n_compared++;
    if ((got & m) !== (xp & m)) begin
      n_mismatch++;
      $display("ERROR %0t: read %h expected %h under mask %h", $time, got, xp, m);
    end
  endtask

  task automatic compare_bit(input logic got, input logic xp);
    n_compared++;
    if (got !== xp) begin
      n_mismatch++;
      $display("ERROR %0t: output bit %b expected %b", $time, got, xp);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // expectation noted now, checked by the monitor when the data stand
  task automatic rreg(input logic [2:0] a, input logic [7:0] xp, input logic [7:0] m);
    exp_q.push_back({m, xp});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) begin
      e = exp_q.pop_front();
      compare_byte(rdata, e[7:0], e[15:8]);
    end
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rreg(3'h1, 8'hFF, 8'hFF);
    rreg(3'h2, 8'hFF, 8'hFF);
    rreg(3'h3, 8'h00, 8'hFF);
    rreg(3'h4, 8'h00, 8'hFF);
    wreg(3'h0, 8'h01);
    rreg(3'h0, 8'h00, 8'hFF);
    rreg(3'h7, 8'h00, 8'hFF);
    $display("reset test done");

    seed = xorshift(seed);
    rld = 16'h0002 + 16'(seed[2:0]);
    dir <= 1'b1;
    pdat <= 1'b1;
    mie <= 1'b1;
    wreg(3'h1, 8'h02);
    wreg(3'h2, 8'h00);
    wreg(3'h3, rld[7:0]);
    wreg(3'h4, 8'h00);
    rreg(3'h3, rld[7:0], 8'hFF);
    wreg(3'h0, 8'hA4);
    wreg(3'h0, 8'hB4);
    compare_bit(pin_o, 1'b1);
    compare_bit(pin_oe, 1'b1);
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
    compare_bit(irq, 1'b1);
    compare_bit(pin_o, 1'b0);
    rreg(3'h0, 8'hBC, 8'hFF);
    wreg(3'h3, 8'h06);
    wreg(3'h0, 8'hB4);
    repeat (2) @(posedge clk);
    compare_bit(irq, 1'b0);
    mie <= 1'b0;
    for (int i = 0; i < 600 && pin_o !== 1'b1; i++) @(posedge clk);
    compare_bit(pin_o, 1'b1);
    repeat (2) @(posedge clk);
    compare_bit(irq, 1'b0);
    mie <= 1'b1;
    repeat (2) @(posedge clk);
    compare_bit(irq, 1'b1);
    // pending kept at 1, enable dropped: the request must fall
    pdat <= 1'b0;
    wreg(3'h0, 8'h88);
    wreg(3'h1, 8'h55);
    compare_bit(irq, 1'b0);
    repeat (200) @(posedge clk);
    rreg(3'h1, 8'h55, 8'hFF);
    compare_bit(pin_o, 1'b0);
    $display("pwm test done");

    dir <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      src.drive(k[0], 150);
      wreg(3'h1, 8'h01);
      wreg(3'h2, 8'h00);
      wreg(3'h3, 8'h05);
      wreg(3'h4, 8'h00);
      wreg(3'h0, {2'b00, k[0], 5'b10100});
      src.drive(!k[0], 100);
      src.drive(k[0], 150);
      rreg(3'h1, 8'h00, 8'hFF);
      compare_bit(irq, 1'b0);
      src.drive(!k[0], 100);
      src.drive(k[0], 150);
      compare_bit(irq, 1'b1);
      rreg(3'h1, 8'h05, 8'hFF);
    end
    $display("event test done");

    src.drive(1'b0, 150);
    wreg(3'h1, 8'hFF);
    wreg(3'h2, 8'hFF);
    wreg(3'h0, 8'h44);
    src.drive(1'b1, 100);
    src.drive(1'b0, 150);
    rreg(3'h0, 8'h4C, 8'hFF);
    rreg(3'h4, 8'hFF, 8'hFF);
    wreg(3'h0, 8'h64);
    wreg(3'h1, 8'h03);
    wreg(3'h2, 8'h00);
    repeat (300) @(posedge clk);
    rreg(3'h0, 8'h74, 8'hFF);
    compare_bit(irq, 1'b1);
    src.drive(1'b1, 100);
    rreg(3'h0, 8'h70, 8'hF8);
    src.drive(1'b0, 150);
    rreg(3'h0, 8'h78, 8'hF8);
    $display("capture test done");

    // bit 5 picks the first edge, bit 5 xor bit 1 the second
    for (int k = 0; k < 4; k++) begin
      kb = k[1:0];
      f = !kb[1];
      s = kb[1] ^ kb[0];
      src.drive(!f, 150);
      wreg(3'h0, {2'b11, kb[1], 3'b001, kb[0], 1'b0});
      src.drive(f, (s == f) ? 450 : 900);
      if (s == f)
        src.drive(!f, 450);
      src.drive(s, 150);
      rreg(3'h3, 8'h10, 8'hF8);
      rreg(3'h4, 8'h00, 8'hFF);
      rreg(3'h0, 8'h08, 8'h08);
    end
    $display("difference test done");
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
